// ---- rtl/ppm_pkg.sv ----
// Purpose: Shared constants and types for the programming-mode port
// Assumes: Supply level arrives already classified as digital flags
// Notes: Memory is byte wide, addressed by 16 bits
`default_nettype none
package ppm_pkg;
  localparam int PPM_DATA_W = 8;
  localparam int PPM_ADDR_W = 16;
  localparam int PPM_MEM_BYTES = 61440;
  localparam logic [15:0] PPM_ADDR_LAST = 16'hefff;
  localparam int PPM_PAGE_BYTES = 4;
  localparam int PPM_PAGE_IDX_W = 2;
  localparam logic [7:0] PPM_ERASED = 8'hff;

  typedef enum logic [3:0] {
    PPM_MODE_OFF,
    PPM_MODE_PAGE_LATCH,
    PPM_MODE_PAGE_WRITE,
    PPM_MODE_BYTE_WRITE,
    PPM_MODE_VERIFY,
    PPM_MODE_INHIBIT,
    PPM_MODE_READ,
    PPM_MODE_OUT_DIS,
    PPM_MODE_STANDBY
  } ppm_mode_t;
endpackage
`default_nettype wire

// ---- rtl/ppm_mode_decode.sv ----
// Purpose: Combinational decode of control pins into programming mode
// Assumes: Pins are static levels sampled by the caller
// Notes: No clock; output follows inputs directly
`default_nettype none
module ppm_mode_decode
  import ppm_pkg::*;
(
  input wire logic i_reset_pin_n,
  input wire logic i_vpp_prog,
  input wire logic i_vpp_read,
  input wire logic i_chip_enable_n,
  input wire logic i_output_enable_n,
  input wire logic i_program_pulse_n,
  output ppm_mode_t o_mode
);
  always_comb
  begin
    o_mode = PPM_MODE_OFF;
    if (!i_reset_pin_n && i_vpp_prog)
    begin
      if (i_output_enable_n == i_program_pulse_n)
        o_mode = PPM_MODE_INHIBIT;
      else if (i_chip_enable_n && !i_output_enable_n)
        o_mode = PPM_MODE_PAGE_LATCH;
      else if (i_chip_enable_n)
        o_mode = PPM_MODE_PAGE_WRITE;
      else if (i_output_enable_n)
        o_mode = PPM_MODE_BYTE_WRITE;
      else
        o_mode = PPM_MODE_VERIFY;
    end
    else if (!i_reset_pin_n && i_vpp_read)
    begin
      if (i_chip_enable_n)
        o_mode = PPM_MODE_STANDBY;
      else if (i_output_enable_n)
        o_mode = PPM_MODE_OUT_DIS;
      else if (i_program_pulse_n)
        o_mode = PPM_MODE_READ;
      else
        o_mode = PPM_MODE_OUT_DIS;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ppm_prom_port.sv ----
// What this block does
// - Programming mode: reset low plus supply
// - High supply decodes latch, page, byte write
// - Verify drives data; inhibit floats pins
// - Low supply read drives stored byte
// - Output enable high floats data pins
// - Chip enable high at low supply means standby, floating
// - Sixty kilobytes reachable for all access
// - Page latch captures four address/data pairs
//
// Purpose: Device side of the pin-driven PROM programming port
// Assumes: Control pins synchronous to i_sys_clk; supply given as flags
// Notes: Memory is modelled as writable array, erased to all ones
`default_nettype none
module ppm_prom_port
  import ppm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_reset_pin_n,
  input wire logic i_vpp_prog,
  input wire logic i_vpp_read,
  input wire logic i_chip_enable_n,
  input wire logic i_output_enable_n,
  input wire logic i_program_pulse_n,
  input wire logic [PPM_ADDR_W-1:0] i_addr,
  input wire logic [PPM_DATA_W-1:0] i_data_pins,
  output logic [PPM_DATA_W-1:0] o_data_pins,
  output logic o_data_pins_oe,
  output ppm_mode_t o_mode
);
  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [PPM_PAGE_BYTES-1:0] pvld;
    logic [PPM_PAGE_BYTES-1:0][PPM_ADDR_W-1:0] paddr;
    logic [PPM_PAGE_BYTES-1:0][PPM_DATA_W-1:0] pdata;
    logic pulse_d;
    logic [PPM_DATA_W-1:0] rdata;
  } ppm_state_t;

  ppm_state_t st_r;
  ppm_state_t st_nxt;
  ppm_mode_t mode;
  // Erased to all ones at power-up; never reset
  logic [PPM_DATA_W-1:0] mem [PPM_MEM_BYTES] = '{default: PPM_ERASED};
  logic pulse_start;
  logic in_range;
  logic [PPM_PAGE_BYTES-1:0] page_commit;
  logic byte_commit;

  function automatic logic addr_ok(input logic [PPM_ADDR_W-1:0] a);
    addr_ok = (a <= PPM_ADDR_LAST);
  endfunction

  // Either write mode holds a program pulse
  function automatic logic is_write(input ppm_mode_t m);
    is_write = (m == PPM_MODE_PAGE_WRITE) || (m == PPM_MODE_BYTE_WRITE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  // continuous decode
  ppm_mode_decode u_decode (
    .i_reset_pin_n(i_reset_pin_n),
    .i_vpp_prog(i_vpp_prog),
    .i_vpp_read(i_vpp_read),
    .i_chip_enable_n(i_chip_enable_n),
    .i_output_enable_n(i_output_enable_n),
    .i_program_pulse_n(i_program_pulse_n),
    .o_mode(mode)
  );
  assign o_mode = mode;
  assign in_range = addr_ok(i_addr);

  assign o_data_pins_oe = (mode == PPM_MODE_VERIFY) ||
                          (mode == PPM_MODE_READ);
  assign o_data_pins = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  assign pulse_start = is_write(mode) && !st_r.pulse_d;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pulse_d = is_write(mode);
    st_nxt.rdata = in_range ? mem[i_addr] : PPM_ERASED;
    if (mode == PPM_MODE_PAGE_LATCH)
    begin
      st_nxt.paddr[i_addr[PPM_PAGE_IDX_W-1:0]] = i_addr;
      st_nxt.pdata[i_addr[PPM_PAGE_IDX_W-1:0]] = i_data_pins;
      st_nxt.pvld[i_addr[PPM_PAGE_IDX_W-1:0]] = 1'b1;
    end
    if (mode == PPM_MODE_PAGE_WRITE && pulse_start)
      st_nxt.pvld = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Commit strobes per page slot
  genvar g;
  generate
    for (g = 0; g < PPM_PAGE_BYTES; g++)
    begin : g_page
      assign page_commit[g] = (mode == PPM_MODE_PAGE_WRITE) && pulse_start &&
                              st_r.pvld[g] && addr_ok(st_r.paddr[g]);
    end
  endgenerate

  assign byte_commit = (mode == PPM_MODE_BYTE_WRITE) && pulse_start &&
                       in_range;

  ////////////////////////////////////////////////////////////////////////
  // Memory array; one writer, programming clears bits only
  always_ff @(posedge i_sys_clk)
  begin
    if (byte_commit)
      mem[i_addr] <= mem[i_addr] & i_data_pins;
    for (int k = 0; k < PPM_PAGE_BYTES; k++)
    begin
      if (page_commit[k])
        mem[st_r.paddr[k]] <= mem[st_r.paddr[k]] & st_r.pdata[k];
    end
  end
endmodule
`default_nettype wire

// ---- testbench/ppm_prom_port_checker.sv ----
// Purpose: Mode and drive checks
// Assumes: Supply flags static
// Notes: Bound from bench
`default_nettype none
module ppm_prom_port_checker
  import ppm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_reset_pin_n,
  input wire logic i_vpp_prog,
  input wire logic i_vpp_read,
  input wire logic i_chip_enable_n,
  input wire logic i_output_enable_n,
  input wire logic i_program_pulse_n,
  input wire logic o_data_pins_oe,
  input wire ppm_mode_t o_mode
);
  wire logic c = i_chip_enable_n;
  wire logic o = i_output_enable_n;
  wire logic g = i_program_pulse_n;
  wire logic d = o_data_pins_oe;
  wire logic p = !i_reset_pin_n && i_vpp_prog;
  wire logic r = !i_reset_pin_n && !i_vpp_prog && i_vpp_read;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_page_latch: assert property (p && c && !o && g |->
    o_mode == PPM_MODE_PAGE_LATCH && !d) else $error("latch");
  a_page_write: assert property (p && c && o && !g |->
    o_mode == PPM_MODE_PAGE_WRITE && !d) else $error("page");
  a_byte_write: assert property (p && !c && o && !g |->
    o_mode == PPM_MODE_BYTE_WRITE && !d) else $error("byte");
  a_prog_verify: assert property (p && !c && !o && g |->
    o_mode == PPM_MODE_VERIFY && d) else $error("verify");
  a_prog_inhibit: assert property (p && o == g |->
    o_mode == PPM_MODE_INHIBIT && !d) else $error("inhibit");
  a_read_mode: assert property (r && !c && !o && g |->
    o_mode == PPM_MODE_READ && d) else $error("read");
  a_out_disable: assert property (r && !c && (o || !g) |->
    o_mode == PPM_MODE_OUT_DIS && !d) else $error("disable");
  a_standby_float: assert property (r && c |->
    o_mode == PPM_MODE_STANDBY && !d) else $error("standby");
endmodule
`default_nettype wire

// ---- testbench/ppm_programmer_model.sv ----
// Purpose: Programmer driving pins
// Assumes: Changes at falling edge
// Notes: Pulse shortened to PULSE
`default_nettype none
module ppm_programmer_model
  import ppm_pkg::*;
#(parameter int PULSE = 3)
(
  input wire logic i_sys_clk,
  input wire logic [7:0] i_q,
  output logic [2:0] o_ctl,
  output logic [15:0] o_a,
  output logic [7:0] o_d
);
  initial {o_ctl, o_a, o_d} = {3'h7, 16'h0, 8'hff};
  task automatic set(input logic [2:0] m, input logic [15:0] a, int n);
    {o_ctl, o_a} = {m, a};
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    set(3'h1, a, 2);
    q = i_q;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    logic [7:0] q;
    if (a > PPM_ADDR_LAST)
      return;
    o_d = v;
    for (int i = 0; i < 10; i++)
    begin
      set(3'h2, a, PULSE);
      rd(a, q);
      if (q === v)
        break;
    end
    set(3'h7, a, 1);
  endtask
  task automatic pg(input logic [15:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
    begin
      o_d = v[8*i +: 8];
      set(3'h5, a | 16'(i), 1);
    end
    set(3'h6, a, PULSE);
    set(3'h7, a, 1);
  endtask
endmodule
`default_nettype wire

// ---- testbench/ppm_prom_port_bench.sv ----
// Purpose: Bench for programming port
// Assumes: Model owns pins
// Notes: Short pulse
`default_nettype none
module ppm_prom_port_bench
  import ppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'h0, i_rstn = 1'h0, i_reset_pin_n = 1'h0;
  logic i_vpp_prog = 1'h1, i_vpp_read = 1'h0, o_data_pins_oe;
  logic i_chip_enable_n, i_output_enable_n, i_program_pulse_n;
  logic [15:0] i_addr;
  logic [7:0] i_data_pins, o_data_pins, q;
  ppm_mode_t o_mode;
  int n_errors = 0, check_count = 0;
  ppm_prom_port dut (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_reset_pin_n(i_reset_pin_n),
    .i_vpp_prog(i_vpp_prog),
    .i_vpp_read(i_vpp_read),
    .i_chip_enable_n(i_chip_enable_n),
    .i_output_enable_n(i_output_enable_n),
    .i_program_pulse_n(i_program_pulse_n),
    .i_addr(i_addr),
    .i_data_pins(i_data_pins),
    .o_data_pins(o_data_pins),
    .o_data_pins_oe(o_data_pins_oe),
    .o_mode(o_mode)
  );
  ppm_programmer_model pm (.i_sys_clk, .i_q(o_data_pins), .o_a(i_addr),
    .o_ctl({i_chip_enable_n, i_output_enable_n, i_program_pulse_n}),
    .o_d(i_data_pins));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task automatic chk(input string s, input logic [7:0] e, v);
    check_count++;
    if (v !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic t_modes();
    for (int s = 0; s < 16; s++)
    begin
      {i_vpp_prog, i_vpp_read} = {s < 8, s >= 8};
      pm.set(3'(s), 16'hf000, 1);
      chk("drive", {7'h0, s % 8 == 1}, {7'h0, o_data_pins_oe});
    end
    $display("modes done");
  endtask
  task automatic t_prog();
    {i_vpp_prog, i_vpp_read} = 2'h2;
    pm.wr(16'hefff, 8'h5a);
    pm.pg(16'h0100, 32'h44332211);
    {i_vpp_prog, i_vpp_read, i_reset_pin_n} = 3'h3;
    pm.wr(16'h0000, 8'h00);
    {i_vpp_prog, i_vpp_read, i_reset_pin_n} = 3'h2;
    pm.rd(16'hefff, q);
    chk("byte", 8'h5a, q);
    for (int i = 0; i < 4; i++)
    begin
      pm.rd(16'h0100 | 16'(i), q);
      chk("page", 8'(8'h11 * (i + 1)), q);
    end
    pm.rd(16'h0000, q);
    chk("refused", 8'hff, q);
    pm.rd(16'hf000, q);
    chk("beyond", 8'hff, q);
    $display("prog done");
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge i_sys_clk);
    i_rstn = 1'h1;
    t_modes();
    t_prog();
    summarize();
  end
endmodule
bind ppm_prom_port ppm_prom_port_checker u_chk (
  .i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn),
  .i_reset_pin_n(i_reset_pin_n),
  .i_vpp_prog(i_vpp_prog),
  .i_vpp_read(i_vpp_read),
  .i_chip_enable_n(i_chip_enable_n),
  .i_output_enable_n(i_output_enable_n),
  .i_program_pulse_n(i_program_pulse_n),
  .o_data_pins_oe(o_data_pins_oe),
  .o_mode(o_mode)
);
`default_nettype wire
